// ---- verilog/hls_pkg.sv ----
// shared constants for the hardware loop setup decoder
package hls_pkg;
  // instruction fields
  localparam logic [6:0] OPC_LOOP    = 7'h7B;
  localparam int         OPC_LSB     = 0;
  localparam int         OPC_MSB     = 6;
  localparam int         IDX_BIT     = 7;
  localparam int         RSV_LSB     = 8;
  localparam int         RSV_MSB     = 11;
  localparam int         FN_LSB      = 12;
  localparam int         FN_MSB      = 14;
  localparam int         SRC_LSB     = 15;
  localparam int         SRC_MSB     = 19;
  localparam int         LIMM_LSB    = 20;
  localparam int         LIMM_MSB    = 31;
  localparam logic [3:0] RSV_ZERO    = 4'h0;
  localparam logic [4:0] SRC_ZERO    = 5'h00;
  localparam logic [11:0] LIMM_ZERO  = 12'h000;
  // function codes
  localparam logic [2:0] FN_BEGIN    = 3'h0;
  localparam logic [2:0] FN_FINISH   = 3'h1;
  localparam logic [2:0] FN_ITER_REG = 3'h2;
  localparam logic [2:0] FN_ITER_IMM = 3'h3;
  localparam logic [2:0] FN_INIT_REG = 3'h4;
  localparam logic [2:0] FN_INIT_IMM = 3'h5;
  // loop geometry
  localparam int         NUM_LOOPS   = 2;
  localparam logic [31:0] NEXT_INSN  = 32'h0000_0004;
  localparam logic [31:0] RST_ADDR   = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT  = 32'h0000_0000;
endpackage : hls_pkg

// ---- verilog/hls_loop_ctx.sv ----
// one loop context: start, end and count storage with redirect check
`timescale 1ns/100ps
`default_nettype none
module hls_loop_ctx #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // setup writes
  input  wire logic         wrBegin,
  input  wire logic         wrFinish,
  input  wire logic         wrCount,
  input  wire logic [W-1:0] beginVal,
  input  wire logic [W-1:0] finishVal,
  input  wire logic [W-1:0] countVal,
  // execution side
  input  wire logic         execValid,
  input  wire logic [W-1:0] execPc,
  input  wire logic         allowHit,
  // state
  output logic [W-1:0]      loopBegin,
  output logic [W-1:0]      loopFinish,
  output logic [W-1:0]      loopCount,
  output logic              hit
);
  logic [W-1:0] begin_q;
  logic [W-1:0] finish_q;
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire          atEnd = execValid && (execPc == finish_q);

  assign hit     = allowHit && atEnd && (count_q > W'(1));
  // setup write wins over the decrement
  assign count_d = wrCount ? countVal :
                   (allowHit && atEnd && count_q != '0) ? count_q - W'(1) :
                   count_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      begin_q  <= hls_pkg::RST_ADDR;
      finish_q <= hls_pkg::RST_ADDR;
      count_q  <= hls_pkg::RST_COUNT;
    end else begin
      if (wrBegin) begin
        begin_q <= beginVal;
      end
      if (wrFinish) begin
        finish_q <= finishVal;
      end
      count_q <= count_d;
    end
  end

  assign loopBegin  = begin_q;
  assign loopFinish = finish_q;
  assign loopCount  = count_q;
endmodule : hls_loop_ctx
`default_nettype wire

// ---- verilog/hls_loop_setup.sv ----
// hardware loop setup decoder with two nested loop contexts
`timescale 1ns/100ps
`default_nettype none
module hls_loop_setup #(
  parameter bit custom_extension_enable = 1'b1,
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // decoded instruction from pipeline
  input  wire logic         insnValid,
  input  wire logic [31:0]  insnWord,
  input  wire logic [W-1:0] insnPc,
  input  wire logic [W-1:0] srcValue,
  // executing instruction address
  input  wire logic         execValid,
  input  wire logic [W-1:0] execPc,
  // decode status
  output logic              loopInsn,
  output logic              illegalLoop,
  // fetch redirect
  output logic              redirect,
  output logic [W-1:0]      redirectPc,
  // loop state
  output logic [W-1:0]      begin0,
  output logic [W-1:0]      finish0,
  output logic [W-1:0]      count0,
  output logic [W-1:0]      begin1,
  output logic [W-1:0]      finish1,
  output logic [W-1:0]      count1
);
  // field extraction
  wire logic [6:0]  opc    = insnWord[hls_pkg::OPC_MSB:hls_pkg::OPC_LSB];
  wire logic        idx    = insnWord[hls_pkg::IDX_BIT];
  wire logic [3:0]  rsv    = insnWord[hls_pkg::RSV_MSB:hls_pkg::RSV_LSB];
  wire logic [2:0]  fn     = insnWord[hls_pkg::FN_MSB:hls_pkg::FN_LSB];
  wire logic [4:0]  srcFld = insnWord[hls_pkg::SRC_MSB:hls_pkg::SRC_LSB];
  wire logic [11:0] limm   = insnWord[hls_pkg::LIMM_MSB:hls_pkg::LIMM_LSB];

  wire logic majorOk = insnValid && opc == hls_pkg::OPC_LOOP
                       && rsv == hls_pkg::RSV_ZERO;
  wire logic srcZero  = srcFld == hls_pkg::SRC_ZERO;
  wire logic limmZero = limm == hls_pkg::LIMM_ZERO;
  wire logic isBegin  = fn == hls_pkg::FN_BEGIN && srcZero;
  wire logic isFinish = fn == hls_pkg::FN_FINISH && srcZero;
  wire logic isIterR  = fn == hls_pkg::FN_ITER_REG && limmZero;
  wire logic isIterI  = fn == hls_pkg::FN_ITER_IMM && srcZero;
  wire logic isInitR  = fn == hls_pkg::FN_INIT_REG;
  wire logic isInitI  = fn == hls_pkg::FN_INIT_IMM;
  wire logic formOk   = isBegin | isFinish | isIterR | isIterI
                        | isInitR | isInitI;

  // nothing decodes when extension is off
  wire logic enabled = custom_extension_enable;
  wire logic accept  = enabled && majorOk && formOk;
  assign loopInsn    = accept;
  // unknown function codes under the loop opcode are flagged when the reserved bits are zero
  assign illegalLoop = enabled && majorOk && !formOk;

  // offsets are unsigned and halfword scaled
  wire logic [W-1:0] longOff  = W'({limm, 1'b0});
  wire logic [W-1:0] shortOff = W'({srcFld, 1'b0});
  // start from pc plus long offset
  wire logic [W-1:0] beginImm = insnPc + longOff;
  // end from pc plus long offset
  wire logic [W-1:0] finishImm = insnPc + longOff;
  // short forms start at next insn
  wire logic [W-1:0] beginNext = insnPc + W'(hls_pkg::NEXT_INSN);
  wire logic [W-1:0] finishShort = insnPc + shortOff;

  wire logic             wrBegin  = accept && (isBegin | isInitR | isInitI);
  wire logic             wrFinish = accept && (isFinish | isInitR | isInitI);
  wire logic             wrCount  = accept && (isIterR | isIterI
                                               | isInitR | isInitI);
  wire logic [W-1:0] beginVal  = isBegin ? beginImm : beginNext;
  // register setup end uses long offset
  wire logic [W-1:0] finishVal = isInitI ? finishShort : finishImm;
  wire logic [W-1:0] countVal  = (isIterR | isInitR) ? srcValue : W'(limm);

  wire logic [1:0] sel = {idx, !idx};

  logic [W-1:0] lb [hls_pkg::NUM_LOOPS];
  logic [W-1:0] lf [hls_pkg::NUM_LOOPS];
  logic [W-1:0] lc [hls_pkg::NUM_LOOPS];
  logic [1:0]   hits;
  logic [1:0]   allow;

  // inner loop (0) has priority; outer only acts if inner does not end here
  wire logic inner0End = execValid && execPc == lf[0] && lc[0] != '0;
  assign allow = {enabled && !inner0End, enabled};

  genvar g;
  generate
    for (g = 0; g < hls_pkg::NUM_LOOPS; g++) begin : gCtx
      hls_loop_ctx #(.W(W)) uCtx (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .wrBegin   (wrBegin && sel[g]),
        .wrFinish  (wrFinish && sel[g]),
        .wrCount   (wrCount && sel[g]),
        .beginVal  (beginVal),
        .finishVal (finishVal),
        .countVal  (countVal),
        .execValid (execValid),
        .execPc    (execPc),
        .allowHit  (allow[g]),
        .loopBegin (lb[g]),
        .loopFinish(lf[g]),
        .loopCount (lc[g]),
        .hit       (hits[g])
      );
    end
  endgenerate

  // redirect to the start of the loop hit
  assign redirect   = |hits;
  assign redirectPc = hits[0] ? lb[0] : (hits[1] ? lb[1] : execPc);

  assign begin0  = lb[0];
  assign finish0 = lf[0];
  assign count0  = lc[0];
  assign begin1  = lb[1];
  assign finish1 = lf[1];
  assign count1  = lc[1];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sBeginImm0;
    accept && isBegin && !idx;
  endsequence
  sequence sInitImm1;
    accept && isInitI && idx;
  endsequence

  begin_imm_a: assert property (sBeginImm0 |=>
    begin0 == $past(insnPc) + W'({$past(limm), 1'b0}))
    else $error("start immediate write wrong");
  finish_imm_a: assert property (accept && isFinish && idx |=>
    finish1 == $past(insnPc) + W'({$past(limm), 1'b0}))
    else $error("end immediate write wrong");
  count_reg_a: assert property (accept && isIterR && !idx |=>
    count0 == $past(srcValue))
    else $error("register count write wrong");
  init_reg_a: assert property (accept && isInitR && !idx |=>
    begin0 == $past(insnPc) + W'(4) && count0 == $past(srcValue))
    else $error("register setup wrong");
  init_imm_a: assert property (sInitImm1 |=>
    finish1 == $past(insnPc) + W'({$past(srcFld), 1'b0})
    && count1 == W'($past(limm)))
    else $error("immediate setup wrong");
  sel_ctx_a: assert property (accept && idx && !wrCount |=>
    $stable(count0) || $past(inner0End))
    else $error("wrong context written");
  decode_op_a: assert property (loopInsn |->
    opc == 7'h7B && rsv == 4'h0 && fn <= 3'h5)
    else $error("bad opcode accepted");
  redir_dec_a: assert property (redirect && hits[0] |=>
    count0 == $past(count0) - W'(1))
    else $error("count not decremented");
  ext_off_a: assert property (!enabled |->
    !loopInsn && !redirect)
    else $error("active while extension off");
  count_imm_a: assert property (accept && isIterI && idx |=>
    count1 == W'($past(limm)))
    else $error("immediate count write wrong");
  // refused forms leave the loop state alone
  illegal_hold_a: assert property (illegalLoop && !execValid |=>
    $stable(begin0) && $stable(finish0) && $stable(count0)
    && $stable(begin1) && $stable(finish1) && $stable(count1))
    else $error("refused form changed state");
  // register setup end uses long offset
  init_end_a: assert property (accept && isInitR && idx |=>
    finish1 == $past(insnPc) + W'({$past(limm), 1'b0})
    && begin1 == $past(insnPc) + W'(4))
    else $error("register setup end wrong");
endmodule : hls_loop_setup
`default_nettype wire

// ---- tb/hls_core_model.sv ----
// pipeline model stepping the executing address
`timescale 1ns/100ps
`default_nettype none
module hls_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bench control
  input  wire logic        run,
  input  wire logic [31:0] startPc,
  // fetch redirect
  input  wire logic        redirect,
  input  wire logic [31:0] redirectPc,
  // executing address
  output logic             execValid,
  output logic [31:0]      execPc
);
  // idle until setup is done
  // reset loads constants only; start address comes in while idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      execValid <= 1'b0;
      execPc    <= 32'h0000_0000;
    end else if (!run) begin
      execValid <= 1'b0;
      execPc    <= startPc;
    end else if (!execValid) begin
      execValid <= 1'b1;
    end else begin
      execPc <= redirect ? redirectPc : execPc + 32'h0000_0004;
    end
  end
endmodule : hls_core_model
`default_nettype wire

// ---- tb/testbench.sv ----
// bench for the loop setup decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        insnValid = 1'b0;
  logic [31:0] insnWord = 32'h0000_0000;
  logic [31:0] insnPc = 32'h0000_0000;
  logic [31:0] srcValue = 32'h0000_0000;
  logic        run = 1'b0;
  logic [31:0] startPc = 32'h0000_0104;
  logic        execValid, loopInsn, illegalLoop, redirect, offInsn;
  logic [31:0] execPc, redirectPc, begin0, finish0, count0;
  logic [31:0] begin1, finish1, count1;
  int          err_total = 0;
  int          checks_done = 0;
  int          hits;
  always #10 clk = ~clk;
  hls_loop_setup u_dut (.clk, .sys_rst, .insnValid, .insnWord, .insnPc,
    .srcValue, .execValid, .execPc, .loopInsn, .illegalLoop, .redirect,
    .redirectPc, .begin0, .finish0, .count0, .begin1, .finish1, .count1);
  hls_loop_setup #(.custom_extension_enable(1'b0)) u_off (.clk, .sys_rst,
    .insnValid, .insnWord, .insnPc, .srcValue, .execValid, .execPc,
    .loopInsn(offInsn), .illegalLoop(), .redirect(), .redirectPc(),
    .begin0(), .finish0(), .count0(), .begin1(), .finish1(), .count1());
  hls_core_model u_core (.clk, .sys_rst, .run, .startPc, .redirect,
    .redirectPc, .execValid, .execPc);
  function automatic logic [31:0] enc(input logic [2:0] fn, input logic l,
    input logic [11:0] imm, input logic [4:0] src);
    return {imm, src, fn, hls_pkg::RSV_ZERO, l, hls_pkg::OPC_LOOP};
  endfunction : enc
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic issue(input logic [31:0] w, pc, src, input logic ok, bad);
    @(negedge clk);
    insnValid = 1'b1;
    insnWord = w;
    insnPc = pc;
    srcValue = src;
    #1;
    chk("loopInsn", {31'h0, loopInsn}, {31'h0, ok});
    chk("illegalLoop", {31'h0, illegalLoop}, {31'h0, bad});
    chk("disabled", {31'h0, offInsn}, 32'h0);
    @(negedge clk);
    insnValid = 1'b0;
  endtask : issue
  task automatic regs(input logic l, input logic [31:0] b, f, c);
    chk("begin", l ? begin1 : begin0, b);
    chk("finish", l ? finish1 : finish0, f);
    chk("count", l ? count1 : count0, c);
  endtask : regs
  // long forms per loop, pc differs so contexts are told apart
  task automatic t_long;
    logic [31:0] pc;
    for (int i = 1; i >= 0; i--) begin
      pc = i ? 32'h0000_1000 : 32'h0000_3000;
      issue(enc(3'h0, i[0], 12'h801, 5'h00), pc, 32'h0, 1'b1, 1'b0);
      issue(enc(3'h1, i[0], 12'hFFF, 5'h00), pc, 32'h0, 1'b1, 1'b0);
      issue(enc(3'h3, i[0], 12'hABC, 5'h00), pc, 32'h0, 1'b1, 1'b0);
      regs(i[0], pc + 32'h1002, pc + 32'h1FFE, 32'hABC);
      issue(enc(3'h2, i[0], 12'h000, 5'h0A), pc, 32'hDEADBEEF, 1'b1, 1'b0);
      regs(i[0], pc + 32'h1002, pc + 32'h1FFE, 32'hDEADBEEF);
    end
    regs(1'b1, 32'h2002, 32'h2FFE, 32'hDEADBEEF);
  endtask : t_long
  // malformed words must leave loop 0 untouched
  task automatic t_bad;
    issue(32'h0000_01FB, 32'h0, 32'h0, 1'b0, 1'b0);
    issue(enc(3'h0, 1'b0, 12'h004, 5'h01), 32'h0, 32'h0, 1'b0, 1'b1);
    issue(enc(3'h2, 1'b0, 12'h001, 5'h01), 32'h0, 32'h5, 1'b0, 1'b1);
    issue(enc(3'h6, 1'b0, 12'h000, 5'h00), 32'h0, 32'h0, 1'b0, 1'b1);
    regs(1'b0, 32'h4002, 32'h4FFE, 32'hDEADBEEF);
  endtask : t_bad
  task automatic t_short;
    issue(enc(3'h4, 1'b1, 12'h010, 5'h03), 32'h4000, 32'h7, 1'b1, 1'b0);
    regs(1'b1, 32'h4004, 32'h4020, 32'h7);
    // body starts right after the setup
    issue(enc(3'h5, 1'b0, 12'h003, 5'h04), 32'h0100, 32'h0, 1'b1, 1'b0);
    regs(1'b0, 32'h0104, 32'h0108, 32'h3);
  endtask : t_short
  // three passes: two redirects, then fall through
  task automatic t_loop;
    hits = 0;
    @(negedge clk);
    run = 1'b1;
    repeat (14) begin
      @(negedge clk);
      if (redirect === 1'b1) begin
        hits++;
        chk("redirectPc", redirectPc, 32'h0104);
      end
    end
    chk("redirects", hits, 32'h2);
    chk("count0", count0, 32'h0);
    chk("count1", count1, 32'h7);
    run = 1'b0;
  endtask : t_loop
  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    regs(1'b0, 32'h0, 32'h0, 32'h0);
    regs(1'b1, 32'h0, 32'h0, 32'h0);
    t_long();
    t_bad();
    t_short();
    t_loop();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
